// >>> hdl/sync_seg_pkg.sv
// Constants for the system control, commit and buffer segment registers
package sync_seg_pkg;
   localparam logic [11:0] SYS_CTRL_OFFSET = 12'h230;
   localparam logic [11:0] UPDATE_OFFSET = 12'h232;
   localparam logic [11:0] SEG_FIRST_OFFSET = 12'hA00;
   localparam logic [11:0] SEG_LAST_OFFSET = 12'hA16;
   localparam int SEG_COUNT = 23;
   localparam int CTRL_ANTIRUNT_OFF_BIT = 3;
   localparam int CTRL_SYNC_PD_BIT = 2;
   localparam int CTRL_DIST_PD_BIT = 1;
   localparam int CTRL_SOFT_SYNC_BIT = 0;
   localparam int UPDATE_BIT = 0;
   localparam logic [3:0] SYS_CTRL_RESET = 4'h0;
   localparam logic [7:0] OP_COMMIT = 8'h80;
   localparam logic [7:0] OP_END = 8'hFF;
   localparam logic [4:0] SEG_LAST_INDEX = 5'h16;
   // Entry: count-1, address high, address low; then commit and end codes
   localparam logic [7:0] SEG_RESET [0:SEG_COUNT-1] = '{
      8'h07, 8'h00, 8'h00,
      8'h1F, 8'h00, 8'h10,
      8'h3F, 8'h00, 8'hF0,
      8'h3F, 8'h01, 8'h90,
      8'h0F, 8'h02, 8'h30,
      OP_COMMIT, OP_END,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_OP = 3'b001,
      ST_ADDR_HI = 3'b010,
      ST_ADDR_LO = 3'b011
   } walk_state_t;
endpackage

// >>> hdl/seg_walker.sv
// Walker that steps the buffer segment entries for the memory controller
`timescale 1ns/1ns
module seg_walker
   import sync_seg_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Controller side
   input wire logic i_start,
   input wire logic [7:0] i_seg_byte,
   output logic [4:0] o_seg_index,
   output logic o_busy,
   output logic o_range_valid,
   output logic [7:0] o_range_count,
   output logic [15:0] o_range_addr,
   output logic o_commit,
   output logic o_done
);
   walk_state_t state_reg, state_next;
   logic [4:0] idx_reg, idx_next;
   logic [7:0] count_reg, count_next;
   logic [15:0] addr_reg, addr_next;
   logic valid_reg, valid_next;
   logic commit_reg, commit_next;
   logic done_reg, done_next;
   logic busy_reg, busy_next;

   always_comb begin
      state_next = state_reg;
      idx_next = idx_reg;
      count_next = count_reg;
      addr_next = addr_reg;
      valid_next = 1'b0;
      commit_next = 1'b0;
      done_next = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (i_start) begin
               idx_next = 5'h00;
               state_next = ST_OP;
            end
         end
         ST_OP: begin
            // Entries are taken in ascending order until the end code
            if (i_seg_byte == OP_END) begin
               done_next = 1'b1;
               state_next = ST_IDLE;
            end else if (i_seg_byte == OP_COMMIT) begin
               commit_next = 1'b1;
               idx_next = idx_reg + 5'h01;
               if (idx_reg == SEG_LAST_INDEX) begin
                  done_next = 1'b1;
                  state_next = ST_IDLE;
               end
            end else if (idx_reg >= SEG_LAST_INDEX - 5'h01) begin
               // Truncated entry at the table end is dropped
               done_next = 1'b1;
               state_next = ST_IDLE;
            end else begin
               count_next = i_seg_byte;
               idx_next = idx_reg + 5'h01;
               state_next = ST_ADDR_HI;
            end
         end
         ST_ADDR_HI: begin
            addr_next = {i_seg_byte, addr_reg[7:0]};
            idx_next = idx_reg + 5'h01;
            state_next = ST_ADDR_LO;
         end
         ST_ADDR_LO: begin
            addr_next = {addr_reg[15:8], i_seg_byte};
            valid_next = 1'b1;
            idx_next = idx_reg + 5'h01;
            if (idx_reg == SEG_LAST_INDEX) begin
               done_next = 1'b1;
               state_next = ST_IDLE;
            end else begin
               state_next = ST_OP;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      // Busy comes from its own flop so the top output needs no gate
      busy_next = (state_next != ST_IDLE);
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_reg <= ST_IDLE;
         idx_reg <= 5'h00;
         count_reg <= 8'h00;
         addr_reg <= 16'h0000;
         valid_reg <= 1'b0;
         commit_reg <= 1'b0;
         done_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         count_reg <= count_next;
         addr_reg <= addr_next;
         valid_reg <= valid_next;
         commit_reg <= commit_next;
         done_reg <= done_next;
         busy_reg <= busy_next;
      end
   end

   assign o_seg_index = idx_reg;
   assign o_busy = busy_reg;
   assign o_range_valid = valid_reg;
   assign o_range_count = count_reg;
   assign o_range_addr = addr_reg;
   assign o_commit = commit_reg;
   assign o_done = done_reg;

   property p_end_stop;
      @(posedge i_clk) disable iff (i_rst)
      (state_reg == ST_OP && i_seg_byte == OP_END) |=> o_done && !o_busy && !o_range_valid;
   endproperty
   a_end_stop: assert property (p_end_stop) else $error("end code did not stop walk");

   property p_commit_code;
      @(posedge i_clk) disable iff (i_rst)
      (state_reg == ST_OP && i_seg_byte == OP_COMMIT) |=> o_commit && !o_range_valid;
   endproperty
   a_commit_code: assert property (p_commit_code) else $error("commit code not issued");

   property p_ascending;
      @(posedge i_clk) disable iff (i_rst)
      (o_busy && $past(o_busy) && idx_reg != $past(idx_reg)) |-> idx_reg == $past(idx_reg) + 5'h01;
   endproperty
   a_ascending: assert property (p_ascending) else $error("segment index not ascending");
endmodule

// >>> hdl/sync_update_eeprom_segment_ctrl.sv
// System sync control, register commit and buffer segment register bank
// Functional notes
// - Control bit 3 at 1 turns the runt-pulse suppression off; at 0 it stays on.
// - Control bit 2 at 1 powers down the output alignment function.
// - Control bit 1 at 1 powers down the distribution reference.
// - Soft alignment bit 0 at 1 holds the channels static, like the pin driven low.
// - A 1-to-0 change of the soft alignment bit fires an alignment event like a pin rise.
// - Writing 1 to update bit 0 copies all buffer registers into the active ones.
// - The update bit clears itself after the copy.
// - The segment bytes hold start addresses and byte counts for save and restore.
// - The segment can also hold a commit code and an end-of-data code.
// - Segment defaults list five address ranges, the last at 0x0230, and then ask for a commit.
`timescale 1ns/1ns
module sync_update_eeprom_segment_ctrl
   import sync_seg_pkg::*;
(
   // Clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_RST,
   // Register access from the serial port decoder
   input wire logic I_REG_WR,
   input wire logic I_REG_RD,
   input wire logic [11:0] I_REG_ADDR,
   input wire logic [7:0] I_REG_WDATA,
   output logic [7:0] O_REG_RDATA,
   output logic O_REG_RVALID,
   // Alignment pin, active low
   input wire logic I_SYNC_N,
   // Distribution controls
   output logic O_ANTIRUNT_EN,
   output logic O_SYNC_PD,
   output logic O_DIST_REF_PD,
   output logic O_SYNC_HOLD,
   output logic O_SYNC_PULSE,
   output logic O_UPDATE_PULSE,
   // Memory controller side
   input wire logic I_NVM_START,
   output logic O_NVM_BUSY,
   output logic O_NVM_RANGE_VALID,
   output logic [7:0] O_NVM_RANGE_COUNT,
   output logic [15:0] O_NVM_RANGE_ADDR,
   output logic O_NVM_DONE
);
   function automatic logic is_seg(input logic [11:0] a);
      is_seg = (a >= SEG_FIRST_OFFSET) && (a <= SEG_LAST_OFFSET);
   endfunction

   logic [3:0] ctrl_reg, ctrl_next;
   logic update_reg, update_next;
   logic [7:0] seg_reg [0:SEG_COUNT-1];
   logic [7:0] seg_next [0:SEG_COUNT-1];
   logic [7:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;
   logic sync_meta_reg, sync_pin_reg;
   logic hold_reg, hold_next;
   logic pulse_reg, pulse_next;
   logic antirunt_reg, antirunt_next;
   logic [4:0] walk_index;
   logic walk_commit;
   logic [4:0] acc_index;
   logic upd_set;

   assign acc_index = 5'(I_REG_ADDR - SEG_FIRST_OFFSET);

   // Register writes and reads
   always_comb begin
      ctrl_next = ctrl_reg;
      rdata_next = rdata_reg;
      rvalid_next = I_REG_RD;
      for (int i = 0; i < SEG_COUNT; i++) begin
         seg_next[i] = seg_reg[i];
      end
      if (I_REG_WR) begin
         if (I_REG_ADDR == SYS_CTRL_OFFSET) begin
            ctrl_next = I_REG_WDATA[3:0];
         end else if (is_seg(I_REG_ADDR)) begin
            seg_next[acc_index] = I_REG_WDATA;
         end
      end
      // Own flop, so the pin needs no gate after the register
      antirunt_next = !ctrl_next[CTRL_ANTIRUNT_OFF_BIT];
      if (I_REG_RD) begin
         if (I_REG_ADDR == SYS_CTRL_OFFSET) begin
            rdata_next = {4'h0, ctrl_reg};
         end else if (I_REG_ADDR == UPDATE_OFFSET) begin
            rdata_next = {7'h00, update_reg};
         end else if (is_seg(I_REG_ADDR)) begin
            rdata_next = seg_reg[acc_index];
         end else begin
            rdata_next = 8'h00;
         end
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         ctrl_reg <= SYS_CTRL_RESET;
         antirunt_reg <= !SYS_CTRL_RESET[CTRL_ANTIRUNT_OFF_BIT];
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
         for (int i = 0; i < SEG_COUNT; i++) begin
            seg_reg[i] <= SEG_RESET[i];
         end
      end else begin
         ctrl_reg <= ctrl_next;
         antirunt_reg <= antirunt_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
         for (int i = 0; i < SEG_COUNT; i++) begin
            seg_reg[i] <= seg_next[i];
         end
      end
   end

   // Commit strobe: host write or walker commit code, one cycle only
   always_comb begin
      upd_set = (I_REG_WR && I_REG_ADDR == UPDATE_OFFSET && I_REG_WDATA[UPDATE_BIT])
         || walk_commit;
      update_next = upd_set;
   end

   // Alignment hold and event; pin passes two flops first
   always_comb begin
      hold_next = (!sync_pin_reg || ctrl_reg[CTRL_SOFT_SYNC_BIT])
         && !ctrl_reg[CTRL_SYNC_PD_BIT];
      pulse_next = hold_reg && !hold_next && !ctrl_reg[CTRL_SYNC_PD_BIT];
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         update_reg <= 1'b0;
         sync_meta_reg <= 1'b1;
         sync_pin_reg <= 1'b1;
         hold_reg <= 1'b0;
         pulse_reg <= 1'b0;
      end else begin
         update_reg <= update_next;
         sync_meta_reg <= I_SYNC_N;
         sync_pin_reg <= sync_meta_reg;
         hold_reg <= hold_next;
         pulse_reg <= pulse_next;
      end
   end

   seg_walker u_walker (
      .i_clk(I_REF_CLK),
      .i_rst(I_RST),
      .i_start(I_NVM_START),
      .i_seg_byte(seg_reg[walk_index]),
      .o_seg_index(walk_index),
      .o_busy(O_NVM_BUSY),
      .o_range_valid(O_NVM_RANGE_VALID),
      .o_range_count(O_NVM_RANGE_COUNT),
      .o_range_addr(O_NVM_RANGE_ADDR),
      .o_commit(walk_commit),
      .o_done(O_NVM_DONE)
   );

   assign O_REG_RDATA = rdata_reg;
   assign O_REG_RVALID = rvalid_reg;
   assign O_ANTIRUNT_EN = antirunt_reg;
   assign O_SYNC_PD = ctrl_reg[CTRL_SYNC_PD_BIT];
   assign O_DIST_REF_PD = ctrl_reg[CTRL_DIST_PD_BIT];
   assign O_SYNC_HOLD = hold_reg;
   assign O_SYNC_PULSE = pulse_reg;
   assign O_UPDATE_PULSE = update_reg;

   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_RST);

   property p_antirunt;
      I_REG_WR && I_REG_ADDR == SYS_CTRL_OFFSET |=> O_ANTIRUNT_EN == !$past(I_REG_WDATA[3]);
   endproperty
   a_antirunt: assert property (p_antirunt) else $error("antirunt enable wrong");

   property p_sync_pd;
      // Hold lags the control bit by one cycle, so the check starts a cycle later
      O_SYNC_PD && $past(O_SYNC_PD) |-> !O_SYNC_HOLD && !O_SYNC_PULSE;
   endproperty
   a_sync_pd: assert property (p_sync_pd) else $error("alignment active while down");

   property p_dist_pd;
      I_REG_WR && I_REG_ADDR == SYS_CTRL_OFFSET |=> O_DIST_REF_PD == $past(I_REG_WDATA[1]);
   endproperty
   a_dist_pd: assert property (p_dist_pd) else $error("distribution power-down wrong");

   property p_soft_hold;
      ctrl_reg[CTRL_SOFT_SYNC_BIT] && !ctrl_reg[CTRL_SYNC_PD_BIT] |=> O_SYNC_HOLD;
   endproperty
   a_soft_hold: assert property (p_soft_hold) else $error("soft bit did not hold");

   property p_soft_edge;
      $fell(ctrl_reg[CTRL_SOFT_SYNC_BIT]) && sync_pin_reg && $past(sync_pin_reg)
         && !ctrl_reg[CTRL_SYNC_PD_BIT] && !$past(ctrl_reg[CTRL_SYNC_PD_BIT])
         |=> O_SYNC_PULSE ##1 !O_SYNC_PULSE;
   endproperty
   a_soft_edge: assert property (p_soft_edge) else $error("no alignment event on fall");

   property p_update;
      I_REG_WR && I_REG_ADDR == UPDATE_OFFSET && I_REG_WDATA[UPDATE_BIT] |=> O_UPDATE_PULSE;
   endproperty
   a_update: assert property (p_update) else $error("commit not issued");

   property p_update_clear;
      O_UPDATE_PULSE && !upd_set |=> !O_UPDATE_PULSE;
   endproperty
   a_update_clear: assert property (p_update_clear) else $error("commit bit stuck");

   property p_seg_read;
      I_REG_RD && I_REG_ADDR == SEG_FIRST_OFFSET && !I_REG_WR
         |=> O_REG_RVALID && O_REG_RDATA == seg_reg[0];
   endproperty
   a_seg_read: assert property (p_seg_read) else $error("segment read wrong");

   property p_walk_commit;
      walk_commit |=> O_UPDATE_PULSE;
   endproperty
   a_walk_commit: assert property (p_walk_commit) else $error("walk commit lost");

   property p_pin_hold;
      !sync_pin_reg && !ctrl_reg[CTRL_SYNC_PD_BIT] |=> O_SYNC_HOLD;
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("pin low did not hold");

   property p_update_read;
      I_REG_RD && I_REG_ADDR == UPDATE_OFFSET
         |=> O_REG_RDATA == {7'h00, $past(O_UPDATE_PULSE)};
   endproperty
   a_update_read: assert property (p_update_read) else $error("commit bit read wrong");
endmodule

// >>> verif/host_port_model.sv
// Host controller model driving the register strobe port
`timescale 1ns/1ns
module host_port_model (
   // Clock
   input wire logic i_clk,
   // Strobe port
   output logic o_wr,
   output logic o_rd,
   output logic [11:0] o_addr,
   output logic [7:0] o_wdata,
   input wire logic [7:0] i_rdata,
   input wire logic i_rvalid
);
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 12'h000;
      o_wdata = 8'h00;
   end
   // One-cycle write strobe; commit is a write of 1 to bit 0
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(posedge i_clk) #1;
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(posedge i_clk) #1;
      o_wr = 1'b0;
      // Released bus must not keep the last value
      o_addr = ~a;
      o_wdata = ~d;
   endtask
   task automatic rd_reg(input logic [11:0] a, output logic [7:0] d, output logic v);
      @(posedge i_clk) #1;
      o_addr = a;
      o_rd = 1'b1;
      @(posedge i_clk) #1;
      d = i_rdata;
      v = i_rvalid;
      o_rd = 1'b0;
      o_addr = ~a;
   endtask
endmodule

// >>> verif/sync_update_eeprom_segment_ctrl_bench.sv
// Self-checking bench for the sync, commit and segment register bank
`timescale 1ns/1ns
module sync_update_eeprom_segment_ctrl_bench;
   import sync_seg_pkg::*;
   logic ref_clk, rst, sync_n, nvm_start, wr, rd, rvalid;
   logic antirunt, sync_pd, dist_pd, hold, spulse, upulse, busy, rng_v, done;
   logic [11:0] addr;
   logic [7:0] wdata, rdata, rng_cnt, v;
   logic [15:0] rng_addr;
   int n_fail, n_checks, n_sync, n_upd, n_rng, n_done, s;
   logic [7:0] last_cnt;
   logic [15:0] last_addr;
   host_port_model HOST (.i_clk(ref_clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
      .o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rvalid));
   sync_update_eeprom_segment_ctrl DUT (.I_REF_CLK(ref_clk), .I_RST(rst), .I_REG_WR(wr),
      .I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
      .O_REG_RVALID(rvalid), .I_SYNC_N(sync_n), .O_ANTIRUNT_EN(antirunt),
      .O_SYNC_PD(sync_pd), .O_DIST_REF_PD(dist_pd), .O_SYNC_HOLD(hold),
      .O_SYNC_PULSE(spulse), .O_UPDATE_PULSE(upulse), .I_NVM_START(nvm_start),
      .O_NVM_BUSY(busy), .O_NVM_RANGE_VALID(rng_v), .O_NVM_RANGE_COUNT(rng_cnt),
      .O_NVM_RANGE_ADDR(rng_addr), .O_NVM_DONE(done));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // Pulse counters, so a one-cycle pulse is never missed
   always @(posedge ref_clk) begin
      if (spulse === 1'b1) n_sync++;
      if (upulse === 1'b1) n_upd++;
      if (done === 1'b1) n_done++;
      if (rng_v === 1'b1) begin
         n_rng++;
         last_cnt = rng_cnt;
         last_addr = rng_addr;
      end
   end
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic vl;
      HOST.rd_reg(a, d, vl);
      chk("rvalid", 16'h0001, {15'h0000, vl});
      chk("rdata", {8'h00, exp}, {8'h00, d});
   endtask
   function automatic logic [2:0] ctl_out(input logic [7:0] c);
      return {~c[3], c[2], c[1]};
   endfunction
   task automatic walk(input int nr, input int nc);
      int r0, c0, d0;
      r0 = n_rng;
      c0 = n_upd;
      d0 = n_done;
      @(posedge ref_clk) #1;
      nvm_start = 1'b1;
      @(posedge ref_clk) #1;
      nvm_start = 1'b0;
      chk("busy", 16'h0001, {15'h0000, busy});
      for (int i = 0; i < 200 && n_done == d0; i++) @(posedge ref_clk);
      #1;
      chk("done", 16'h0001, 16'(n_done - d0));
      chk("idle", 16'h0000, {15'h0000, busy});
      chk("ranges", 16'(nr), 16'(n_rng - r0));
      chk("commits", 16'(nc), 16'(n_upd - c0));
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #(40 * 6000);
      n_fail++;
      tally_and_finish;
   end
   initial begin
      rst = 1'b1;
      sync_n = 1'b1;
      nvm_start = 1'b0;
      s = $urandom(32'hAEA8);
      repeat (16) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      chk("ctl reset", 16'h0004, {13'h0000, ctl_out(8'h00)} & {13'h0000, antirunt, sync_pd, dist_pd});
      chk("pd reset", 16'h0000, {14'h0000, sync_pd, dist_pd});
      rd_chk(SYS_CTRL_OFFSET, 8'h00);
      rd_chk(12'h231, 8'h00);
      for (int i = 0; i < SEG_COUNT; i++) rd_chk(SEG_FIRST_OFFSET + 12'(i), SEG_RESET[i]);
      walk(5, 1);
      chk("last range", 16'h0230, last_addr);
      chk("last count", 16'h000F, {8'h00, last_cnt});
      // Random control values; last one probes the unused upper bits
      for (int i = 0; i < 8; i++) begin
         v = (i == 7) ? 8'hF0 : 8'($urandom) & 8'h0E;
         HOST.wr_reg(SYS_CTRL_OFFSET, v);
         chk("ctl outs", {13'h0000, ctl_out(v)}, {13'h0000, antirunt, sync_pd, dist_pd});
         rd_chk(SYS_CTRL_OFFSET, v & 8'h0F);
      end
      HOST.wr_reg(SYS_CTRL_OFFSET, 8'h01);
      @(posedge ref_clk) #1;
      chk("soft hold", 16'h0001, {15'h0000, hold});
      s = n_sync;
      HOST.wr_reg(SYS_CTRL_OFFSET, 8'h00);
      repeat (3) @(posedge ref_clk);
      #1;
      chk("soft event", 16'h0001, 16'(n_sync - s));
      chk("soft release", 16'h0000, {15'h0000, hold});
      sync_n = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
      chk("pin hold", 16'h0001, {15'h0000, hold});
      s = n_sync;
      sync_n = 1'b1;
      repeat (5) @(posedge ref_clk);
      #1;
      chk("pin event", 16'h0001, 16'(n_sync - s));
      // Powered-down alignment ignores the pin entirely
      HOST.wr_reg(SYS_CTRL_OFFSET, 8'h04);
      sync_n = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
      chk("pd hold", 16'h0000, {15'h0000, hold});
      s = n_sync;
      sync_n = 1'b1;
      repeat (5) @(posedge ref_clk);
      #1;
      chk("pd event", 16'h0000, 16'(n_sync - s));
      HOST.wr_reg(SYS_CTRL_OFFSET, 8'h00);
      s = n_upd;
      HOST.wr_reg(UPDATE_OFFSET, 8'h01);
      chk("commit", 16'h0001, {15'h0000, upulse});
      @(posedge ref_clk) #1;
      chk("commit clear", 16'h0000, {15'h0000, upulse});
      rd_chk(UPDATE_OFFSET, 8'h00);
      HOST.wr_reg(UPDATE_OFFSET, 8'h00);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("commit count", 16'h0001, 16'(n_upd - s));
      v = 8'($urandom);
      s = 17 + ($urandom % 6);
      HOST.wr_reg(SEG_FIRST_OFFSET + 12'(s), v);
      rd_chk(SEG_FIRST_OFFSET + 12'(s), v);
      HOST.wr_reg(SEG_FIRST_OFFSET + 12'h003, OP_END);
      walk(1, 0);
      chk("first range", 16'h0000, last_addr);
      chk("first count", 16'h0007, {8'h00, last_cnt});
      tally_and_finish;
   end
endmodule
